// [dv/awu_top_test.sv]
// Self-checking bench for the auto wake-up unit over classic Wishbone.
// Assumes the unit's own assertions run inside awu_top beside this bench.
`timescale 1ns/100ps
`default_nettype none
module awu_top_test;
   logic clock_in = 1'b0;
   logic nrst_in = 1'b0;
   logic cyc = 1'b0;
   logic stb = 1'b0;
   logic we = 1'b0;
   logic [9:0] adr = 10'h000;
   logic [3:0] sel = 4'h0;
   logic [31:0] wdat = 32'h0;
   logic [31:0] rdat;
   logic ack;
   logic halt_exec = 1'b0;
   logic exit_irq = 1'b0;
   logic pend = 1'b0;
   logic wdg_en = 1'b0;
   logic cc_pop = 1'b0;
   logic act_halt = 1'b0;
   logic rc_clk = 1'b0;
   logic main_osc, periph, rc_on, rc_cap, resume, wake_irq;
   logic wdg_rst, mask_clr, irq;
   logic [1:0] level;
   logic [2:0] watch;
   logic [31:0] exp_q[$];
   int n_errors = 0;
   int compares = 0;
   int seed = 32'h9D83A797;

   assign watch = {resume, wake_irq, wdg_rst};

   awu_top #(.RC_START_NS(100), .PLL_START_NS(200), .ZERO_WAKES(1'h1))
   dut_u (.clock_in(clock_in), .nrst_in(nrst_in), .wb_cyc_in(cyc),
      .wb_stb_in(stb), .wb_we_in(we), .wb_adr_in(adr), .wb_sel_in(sel),
      .wb_dat_in(wdat), .wb_dat_out(rdat), .wb_ack_out(ack),
      .halt_exec_in(halt_exec), .active_halt_in(act_halt),
      .watchdog_en_in(wdg_en), .exit_irq_in(exit_irq),
      .irq_pending_in(pend), .cc_pop_in(cc_pop), .rc_clk_in(rc_clk),
      .main_osc_on_out(main_osc), .periph_clk_en_out(periph),
      .rc_osc_on_out(rc_on), .rc_capture_out(rc_cap),
      .cpu_resume_out(resume), .wake_irq_out(wake_irq),
      .watchdog_reset_out(wdg_rst), .cc_mask_clear_out(mask_clr),
      .cc_level_out(level), .irq_out(irq));

   always #50 clock_in = ~clock_in;
   // The RC oscillator only runs while enabled; odd half period keeps
   // its edges away from the system clock edges.
   always #347 rc_clk = rc_on ? ~rc_clk : 1'b0;

   task automatic check(input logic [31:0] seen, input logic [31:0] want);
      compares++;
      if (seen !== want) begin
         n_errors++;
         $display("[ERR] %0t seen %h want %h", $time, seen, want);
      end
   endtask

   task automatic tally_and_finish;
      $display("errors %0d compares %0d", n_errors, compares);
      if (n_errors == 0 && compares > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask

   // Read data is compared at the ack edge against the oldest note.
   always @(posedge clock_in) begin
      if (ack === 1'b1 && we === 1'b0) begin
         if (exp_q.size() == 0) begin
            check(rdat, 32'hFFFFFFFF);
         end else begin
            check(rdat, exp_q.pop_front());
         end
      end
   end

   task automatic bus(input logic w, input logic [7:0] idx,
                      input logic [7:0] d, input logic [3:0] s);
      int n;
      n = 0;
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= {idx, 2'b00};
      sel <= s;
      wdat <= {24'h000000, d};
      do begin
         @(posedge clock_in);
         n++;
      end while (ack !== 1'b1 && n < 20);
      if (n >= 20) begin
         n_errors++;
      end
      cyc <= 1'b0;
      stb <= 1'b0;
      we <= 1'b0;
      @(posedge clock_in);
   endtask

   task automatic wr(input logic [7:0] idx, input logic [7:0] d);
      bus(1'b1, idx, d, 4'h1);
   endtask

   task automatic rd(input logic [7:0] idx, input logic [7:0] want);
      exp_q.push_back({24'h000000, want});
      bus(1'b0, idx, 8'h00, 4'hF);
   endtask

   task automatic pulse(input int which);
      if (which == 0) halt_exec <= 1'b1;
      else if (which == 1) exit_irq <= 1'b1;
      else cc_pop <= 1'b1;
      @(posedge clock_in);
      halt_exec <= 1'b0;
      exit_irq <= 1'b0;
      cc_pop <= 1'b0;
   endtask

   task automatic wait_bit(input int b, input int lim, output int n);
      n = 0;
      while (watch[b] !== 1'b1 && n < lim) begin
         @(posedge clock_in);
         n++;
      end
      if (n >= lim) begin
         n_errors++;
      end
   endtask

   initial begin
      int n;
      int m;
      logic [7:0] v;
      repeat (3) @(posedge clock_in);
      nrst_in <= 1'b1;
      repeat (3) @(posedge clock_in);
      rd(8'h49, 8'hFF);
      rd(8'h4A, 8'h00);
      rd(8'h4C, 8'h00);
      rd(8'h4E, 8'h00);
      wr(8'h50, 8'h55);
      rd(8'h50, 8'h00);
      for (int i = 0; i < 4; i++) begin
         v = 8'($random(seed)) | 8'h01;
         wr(8'h49, v);
         rd(8'h49, v);
      end
      bus(1'b1, 8'h49, 8'h20, 4'h0);
      rd(8'h49, v);
      wr(8'h4A, 8'h04);
      rd(8'h4A, 8'h00);
      // Auto wake with prescaler 2: 128 RC periods of 694 ns.
      wr(8'h49, 8'h02);
      wr(8'h4C, 8'h01);
      wr(8'h4A, 8'h01);
      pulse(0);
      @(posedge clock_in);
      check(32'(mask_clr), 32'h1);
      @(posedge clock_in);
      check(32'({periph, main_osc, rc_on}), 32'h1);
      wait_bit(1, 2000, n);
      check(32'(n >= 870 && n <= 910), 32'h1);
      wait_bit(2, 600, m);
      check(32'(m >= 250 && m <= 260), 32'h1);
      rd(8'h4A, 8'h05);
      rd(8'h4A, 8'h01);
      rd(8'h4B, 8'h01);
      check(32'(irq), 32'h1);
      wr(8'h4C, 8'h00);
      @(posedge clock_in);
      check(32'(irq), 32'h0);
      wr(8'h4C, 8'h01);
      @(posedge clock_in);
      check(32'(irq), 32'h1);
      wr(8'h4B, 8'h01);
      @(posedge clock_in);
      check(32'(irq), 32'h0);
      // Long stabilisation, PLL wait and routine level 2.
      wr(8'h4D, 8'h16);
      pulse(0);
      wait_bit(1, 2000, n);
      wait_bit(2, 6000, m);
      check(32'(m >= 4096 && m <= 4110), 32'h1);
      @(posedge clock_in);
      check(32'({periph, level}), 32'h6);
      pulse(2);
      @(posedge clock_in);
      check(32'(level), 32'h0);
      rd(8'h4A, 8'h05);
      // Plain halt left by another interrupt; active halt is not ours.
      wr(8'h4A, 8'h00);
      act_halt <= 1'b1;
      pulse(0);
      repeat (2) @(posedge clock_in);
      rd(8'h4E, 8'h00);
      act_halt <= 1'b0;
      pulse(0);
      repeat (2) @(posedge clock_in);
      rd(8'h4E, 8'h03);
      pulse(1);
      wait_bit(2, 6000, m);
      rd(8'h4B, 8'h03);
      // Watchdog running, halt not allowed, then allowed by option.
      wdg_en <= 1'b1;
      wr(8'h4D, 8'h00);
      pulse(0);
      wait_bit(0, 5, n);
      rd(8'h4E, 8'h00);
      wr(8'h4D, 8'h01);
      pulse(0);
      repeat (2) @(posedge clock_in);
      rd(8'h4E, 8'h03);
      pulse(1);
      wait_bit(2, 600, m);
      wdg_en <= 1'b0;
      // A pending interrupt skips the RC count.
      pend <= 1'b1;
      wr(8'h4A, 8'h01);
      pulse(0);
      wait_bit(2, 600, m);
      check(32'(m < 300), 32'h1);
      rd(8'h4A, 8'h01);
      pend <= 1'b0;
      // Zero prescaler wakes at once in this variant.
      wr(8'h49, 8'h00);
      rd(8'h49, 8'h00);
      pulse(0);
      wait_bit(1, 20, n);
      wait_bit(2, 600, m);
      rd(8'h4A, 8'h05);
      // Measurement routes the RC clock to the capture output.
      wr(8'h4A, 8'h02);
      repeat (3) @(posedge clock_in);
      n = 0;
      v[0] = rc_cap;
      for (int i = 0; i < 60; i++) begin
         @(posedge clock_in);
         n += int'(rc_cap !== v[0]);
         v[0] = rc_cap;
      end
      check(32'({rc_on, 1'(n > 4)}), 32'h3);
      wr(8'h4A, 8'h00);
      check(32'(exp_q.size()), 32'h0);
      tally_and_finish;
   end

   // Expected run is about 11300 cycles.
   initial begin
      #4000000;
      n_errors++;
      tally_and_finish;
   end
endmodule
`default_nettype wire

// [inc/awu_pkg.sv]
// Constants, types and register map of the auto wake-up unit.
// Assumes a 10 MHz system clock and a 32-bit classic Wishbone bus.
// Function
// - Halt with wake enable set enters auto wake halt and starts RC oscillator.
// - Halt with wake enable clear and no active-halt condition enters plain halt.
// - RC clock is divided by a fixed divider, then the prescaler, to end delay.
// - Halt time is 64 times prescaler RC periods plus RC start-up time.
// - On expiry hardware sets the wake flag and raises the wake interrupt.
// - Wake restarts main oscillator, waits 256 or 4096 cycles, then CPU resumes.
// - Reading control/status clears the wake flag and its pending interrupt.
// - Software writes to the wake flag are ignored.
// - Measure bit in run enables RC oscillator and routes it to timer capture.
// - Wake enable is software controlled; when set, halt wakes after the delay.
// - Prescaler value is the division factor, 1 to 255; zero is forbidden.
// - Zero prescaler either wakes at once or is never stored, per variant.
// - Halt entry forces the interrupt mask to zero; pending interrupt wakes.
// - In halt main oscillator and peripheral clocks stop; RC oscillator may run.
// - Reset or any halt-exit interrupt leaves the mode.
// - Halt with watchdog running gives watchdog reset unless the option permits.
// - With the PLL option the clock output waits an extra start-up interval.
// - Interrupt entry saves priority and sets the routine level; pop restores. The code does this only on a resume with the wake flag set.
package awu_pkg;
   localparam int CLK_MHZ = 10;
   localparam int NS_PER_US = 1000;
   localparam int WAIT_W = 16;

   localparam logic [7:0] IDX_PRESCALER = 8'h49;
   localparam logic [7:0] IDX_CSR = 8'h4A;
   localparam logic [7:0] IDX_EVT_STATUS = 8'h4B;
   localparam logic [7:0] IDX_EVT_MASK = 8'h4C;
   localparam logic [7:0] IDX_OPTIONS = 8'h4D;
   localparam logic [7:0] IDX_STATE = 8'h4E;

   localparam logic [7:0] PRESCALER_RESET = 8'hFF;
   localparam logic [7:0] PRE_FORBIDDEN = 8'h00;
   localparam int CSR_W = 3;
   localparam int CSR_EN_BIT = 0;
   localparam int CSR_MEAS_BIT = 1;
   localparam int EVT_W = 3;
   localparam int OPT_W = 5;
   localparam int STATE_W = 3;

   localparam logic [5:0] FIXED_DIV_LAST = 6'h3F;
   localparam logic [15:0] STAB_SHORT_LAST = 16'h00FF;
   localparam logic [15:0] STAB_LONG_LAST = 16'h0FFF;
   localparam logic [1:0] CC_LEVEL_OPEN = 2'h0;
   localparam logic [1:0] CC_LEVEL_RESET = 2'h3;

   typedef enum logic [2:0] {
      AWU_ST_RUN = 3'h0,
      AWU_ST_RC_START = 3'h1,
      AWU_ST_COUNT = 3'h2,
      AWU_ST_HALT = 3'h3,
      AWU_ST_STAB = 3'h4,
      AWU_ST_PLL = 3'h5
   } awu_state_t;

   typedef struct packed {
      logic wake_flag;
      logic rc_measure_enable;
      logic wake_enable;
   } awu_csr_t;

   typedef struct packed {
      logic [1:0] wake_level;
      logic pll_en;
      logic long_stab;
      logic watchdog_halt_option;
   } awu_opt_t;

   typedef struct packed {
      logic wdg_reset;
      logic exit_wake;
      logic wake;
   } awu_evt_t;

   localparam awu_csr_t CSR_RESET = 3'h0;
   localparam awu_opt_t OPT_RESET = 5'h00;
endpackage

// [verilog/awu_divcnt.sv]
// Wrapping tick counter used for each stage of the wake-up divider chain.
// Assumes ticks and clear come from logic on the same clock.
`timescale 1ns/100ps
`default_nettype none
module awu_divcnt #(
   parameter int W = 8
) (
   input wire logic clock_in,
   input wire logic rst_n_in,
   input wire logic clear_in,
   input wire logic tick_in,
   input wire logic [W-1:0] last_in,
   output logic tick_out
);
   logic [W-1:0] count;

   always_ff @(posedge clock_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         count <= '0;
      end else if (clear_in) begin
         count <= '0;
      end else if (tick_in) begin
         count <= (count == last_in) ? '0 : count + 1'b1;
      end
   end

   assign tick_out = tick_in && !clear_in && (count == last_in);
endmodule
`default_nettype wire

// [verilog/awu_top.sv]
// Auto wake-up unit: halt sequencer, RC divider chain and registers.
// Assumes a CPU halt strobe on clock_in and a free RC clock on a pin.
`timescale 1ns/100ps
`default_nettype none
module awu_top #(
   parameter int RC_START_NS = 20000,
   parameter int PLL_START_NS = 100000,
   parameter bit ZERO_WAKES = 1'h1
) (
   input wire logic clock_in,
   input wire logic nrst_in,
   input wire logic wb_cyc_in,
   input wire logic wb_stb_in,
   input wire logic wb_we_in,
   input wire logic [9:0] wb_adr_in,
   input wire logic [3:0] wb_sel_in,
   input wire logic [31:0] wb_dat_in,
   output logic [31:0] wb_dat_out,
   output logic wb_ack_out,
   input wire logic halt_exec_in,
   input wire logic active_halt_in,
   input wire logic watchdog_en_in,
   input wire logic exit_irq_in,
   input wire logic irq_pending_in,
   input wire logic cc_pop_in,
   input wire logic rc_clk_in,
   output logic main_osc_on_out,
   output logic periph_clk_en_out,
   output logic rc_osc_on_out,
   output logic rc_capture_out,
   output logic cpu_resume_out,
   output logic wake_irq_out,
   output logic watchdog_reset_out,
   output logic cc_mask_clear_out,
   output logic [1:0] cc_level_out,
   output logic irq_out
);
   localparam int RC_CYC_RAW =
      (RC_START_NS * awu_pkg::CLK_MHZ + awu_pkg::NS_PER_US - 1)
      / awu_pkg::NS_PER_US;
   localparam int PLL_CYC_RAW =
      (PLL_START_NS * awu_pkg::CLK_MHZ + awu_pkg::NS_PER_US - 1)
      / awu_pkg::NS_PER_US;
   localparam int RC_CYC = (RC_CYC_RAW < 1) ? 1 : RC_CYC_RAW;
   localparam int PLL_CYC = (PLL_CYC_RAW < 1) ? 1 : PLL_CYC_RAW;
   localparam logic [15:0] RC_LAST = 16'(RC_CYC - 1);
   localparam logic [15:0] PLL_LAST = 16'(PLL_CYC - 1);

   logic rst_meta;
   logic rst_n;
   logic rc_s1;
   logic rc_s2;
   logic rc_s3;
   logic rc_edge;

   logic [7:0] idx;
   logic req;
   logic wr;
   logic rd;
   logic [31:0] next_rdata;

   logic [7:0] prescaler;
   logic [7:0] pre_last;
   awu_pkg::awu_csr_t csr;
   awu_pkg::awu_opt_t opts;
   awu_pkg::awu_evt_t evt_status;
   awu_pkg::awu_evt_t evt_mask;
   awu_pkg::awu_evt_t evt_set;
   awu_pkg::awu_evt_t evt_clr;

   awu_pkg::awu_state_t state;
   logic [awu_pkg::WAIT_W-1:0] wait_cnt;
   logic [awu_pkg::WAIT_W-1:0] wait_last;
   logic wait_done;
   logic halt_state;
   logic wdg_trip;
   logic halt_go;
   logic zero_pre;
   logic set_flag;
   logic exit_wake;
   logic resume;
   logic meas_run;
   logic count_clr;
   logic div_tick;
   logic expire;
   logic [1:0] cc_saved;

   default clocking awu_cb @(posedge clock_in);
   endclocking
   default disable iff (!rst_n);

   // The reset is released in step with the clock; assertion stays async.
   always_ff @(posedge clock_in or negedge nrst_in) begin
      if (!nrst_in) begin
         rst_meta <= 1'h0;
         rst_n <= 1'h0;
      end else begin
         rst_meta <= 1'h1;
         rst_n <= rst_meta;
      end
   end

   // The RC clock is slow against clock_in, so it is sampled as a level.
   always_ff @(posedge clock_in or negedge rst_n) begin
      if (!rst_n) begin
         rc_s1 <= 1'h0;
         rc_s2 <= 1'h0;
         rc_s3 <= 1'h0;
      end else begin
         rc_s1 <= rc_clk_in;
         rc_s2 <= rc_s1;
         rc_s3 <= rc_s2;
      end
   end

   assign rc_edge = rc_s2 & ~rc_s3;

   assign idx = wb_adr_in[9:2];
   assign req = wb_cyc_in & wb_stb_in & ~wb_ack_out;
   assign wr = req & wb_we_in & wb_sel_in[0];
   assign rd = req & ~wb_we_in;

   always_ff @(posedge clock_in or negedge rst_n) begin
      if (!rst_n) begin
         prescaler <= awu_pkg::PRESCALER_RESET;
      end else if (wr && idx == awu_pkg::IDX_PRESCALER) begin
         // A variant that cannot wake on zero simply keeps the old value.
         if (ZERO_WAKES || wb_dat_in[7:0] != awu_pkg::PRE_FORBIDDEN) begin
            prescaler <= wb_dat_in[7:0];
         end
      end
   end

   always_ff @(posedge clock_in or negedge rst_n) begin
      if (!rst_n) begin
         csr <= awu_pkg::CSR_RESET;
      end else begin
         if (wr && idx == awu_pkg::IDX_CSR) begin
            csr.wake_enable <= wb_dat_in[awu_pkg::CSR_EN_BIT];
            csr.rc_measure_enable <= wb_dat_in[awu_pkg::CSR_MEAS_BIT];
         end
         // The flag ignores writes; a wake in the read cycle is kept.
         if (set_flag) begin
            csr.wake_flag <= 1'h1;
         end else if (rd && idx == awu_pkg::IDX_CSR) begin
            csr.wake_flag <= 1'h0;
         end
      end
   end

   always_ff @(posedge clock_in or negedge rst_n) begin
      if (!rst_n) begin
         opts <= awu_pkg::OPT_RESET;
         evt_mask <= '0;
      end else if (wr && idx == awu_pkg::IDX_OPTIONS) begin
         opts <= wb_dat_in[awu_pkg::OPT_W-1:0];
      end else if (wr && idx == awu_pkg::IDX_EVT_MASK) begin
         evt_mask <= wb_dat_in[awu_pkg::EVT_W-1:0];
      end
   end

   always_comb begin
      next_rdata = 32'h0;
      case (idx)
         awu_pkg::IDX_PRESCALER: next_rdata[7:0] = prescaler;
         awu_pkg::IDX_CSR: next_rdata[awu_pkg::CSR_W-1:0] = csr;
         awu_pkg::IDX_EVT_STATUS:
            next_rdata[awu_pkg::EVT_W-1:0] = evt_status;
         awu_pkg::IDX_EVT_MASK: next_rdata[awu_pkg::EVT_W-1:0] = evt_mask;
         awu_pkg::IDX_OPTIONS: next_rdata[awu_pkg::OPT_W-1:0] = opts;
         awu_pkg::IDX_STATE: next_rdata[awu_pkg::STATE_W-1:0] = state;
         default: next_rdata = 32'h0;
      endcase
   end

   always_ff @(posedge clock_in or negedge rst_n) begin
      if (!rst_n) begin
         wb_ack_out <= 1'h0;
         wb_dat_out <= 32'h0;
      end else begin
         wb_ack_out <= req;
         if (rd) begin
            wb_dat_out <= next_rdata;
         end
      end
   end

   assign halt_state = (state == awu_pkg::AWU_ST_RC_START)
      || (state == awu_pkg::AWU_ST_COUNT)
      || (state == awu_pkg::AWU_ST_HALT);
   assign wdg_trip = (state == awu_pkg::AWU_ST_RUN) && halt_exec_in
      && watchdog_en_in && !opts.watchdog_halt_option;
   assign halt_go = (state == awu_pkg::AWU_ST_RUN) && halt_exec_in
      && !wdg_trip;
   assign zero_pre = (prescaler == awu_pkg::PRE_FORBIDDEN);
   assign exit_wake = halt_state && exit_irq_in;
   assign set_flag = ((state == awu_pkg::AWU_ST_COUNT) && expire)
      || (halt_go && !irq_pending_in && csr.wake_enable && zero_pre);
   assign meas_run = csr.rc_measure_enable
      && (state == awu_pkg::AWU_ST_RUN);
   assign count_clr = (state != awu_pkg::AWU_ST_COUNT);

   assign wait_last = (state == awu_pkg::AWU_ST_RC_START) ? RC_LAST
      : (state == awu_pkg::AWU_ST_PLL) ? PLL_LAST
      : opts.long_stab ? awu_pkg::STAB_LONG_LAST
      : awu_pkg::STAB_SHORT_LAST;
   assign wait_done = (wait_cnt == wait_last);
   assign resume = wait_done && ((state == awu_pkg::AWU_ST_PLL)
      || ((state == awu_pkg::AWU_ST_STAB) && !opts.pll_en));

   assign pre_last = prescaler - 8'h01;

   // Fixed divide-by-64 followed by the programmable prescaler.
   awu_divcnt #(.W(6)) fixed_div (
      .clock_in(clock_in),
      .rst_n_in(rst_n),
      .clear_in(count_clr),
      .tick_in(rc_edge),
      .last_in(awu_pkg::FIXED_DIV_LAST),
      .tick_out(div_tick)
   );

   awu_divcnt #(.W(8)) pre_div (
      .clock_in(clock_in),
      .rst_n_in(rst_n),
      .clear_in(count_clr),
      .tick_in(div_tick),
      .last_in(pre_last),
      .tick_out(expire)
   );

   always_ff @(posedge clock_in or negedge rst_n) begin
      if (!rst_n) begin
         state <= awu_pkg::AWU_ST_RUN;
         wait_cnt <= '0;
      end else begin
         wait_cnt <= wait_cnt + 16'h0001;
         unique case (state)
            awu_pkg::AWU_ST_RUN: begin
               wait_cnt <= '0;
               if (halt_go) begin
                  if (irq_pending_in) begin
                     state <= awu_pkg::AWU_ST_STAB;
                  end else if (csr.wake_enable) begin
                     state <= zero_pre ? awu_pkg::AWU_ST_STAB
                        : awu_pkg::AWU_ST_RC_START;
                  end else if (!active_halt_in) begin
                     state <= awu_pkg::AWU_ST_HALT;
                  end
               end
            end
            awu_pkg::AWU_ST_RC_START: begin
               // The RC start-up time is spent before any RC edge counts.
               if (exit_irq_in || wait_done) begin
                  wait_cnt <= '0;
                  state <= exit_irq_in ? awu_pkg::AWU_ST_STAB
                     : awu_pkg::AWU_ST_COUNT;
               end
            end
            awu_pkg::AWU_ST_COUNT: begin
               wait_cnt <= '0;
               if (expire || exit_irq_in) begin
                  state <= awu_pkg::AWU_ST_STAB;
               end
            end
            awu_pkg::AWU_ST_HALT: begin
               wait_cnt <= '0;
               if (exit_irq_in) begin
                  state <= awu_pkg::AWU_ST_STAB;
               end
            end
            awu_pkg::AWU_ST_STAB: begin
               if (wait_done) begin
                  wait_cnt <= '0;
                  state <= opts.pll_en ? awu_pkg::AWU_ST_PLL
                     : awu_pkg::AWU_ST_RUN;
               end
            end
            awu_pkg::AWU_ST_PLL: begin
               if (wait_done) begin
                  wait_cnt <= '0;
                  state <= awu_pkg::AWU_ST_RUN;
               end
            end
            default: begin
               state <= awu_pkg::AWU_ST_RUN;
            end
         endcase
      end
   end

   assign evt_set = '{wdg_reset: wdg_trip, exit_wake: exit_wake,
      wake: set_flag};
   assign evt_clr = (wr && idx == awu_pkg::IDX_EVT_STATUS)
      ? wb_dat_in[awu_pkg::EVT_W-1:0] : '0;

   // Ones written clear status bits, but a new event in that cycle stays.
   always_ff @(posedge clock_in or negedge rst_n) begin
      if (!rst_n) begin
         evt_status <= '0;
         irq_out <= 1'h0;
      end else begin
         evt_status <= (evt_status & ~evt_clr) | evt_set;
         irq_out <= |(evt_status & evt_mask);
      end
   end

   // Outputs follow the sequencer one clock later so they stay glitch free.
   always_ff @(posedge clock_in or negedge rst_n) begin
      if (!rst_n) begin
         main_osc_on_out <= 1'h1;
         periph_clk_en_out <= 1'h1;
         rc_osc_on_out <= 1'h0;
         rc_capture_out <= 1'h0;
         cpu_resume_out <= 1'h0;
         wake_irq_out <= 1'h0;
         watchdog_reset_out <= 1'h0;
         cc_mask_clear_out <= 1'h0;
      end else begin
         main_osc_on_out <= !halt_state;
         periph_clk_en_out <= (state == awu_pkg::AWU_ST_RUN);
         rc_osc_on_out <= (state == awu_pkg::AWU_ST_RC_START)
            || (state == awu_pkg::AWU_ST_COUNT) || meas_run;
         rc_capture_out <= meas_run && rc_s2;
         cpu_resume_out <= resume;
         wake_irq_out <= csr.wake_flag;
         watchdog_reset_out <= wdg_trip;
         cc_mask_clear_out <= halt_go;
      end
   end

   // Interrupt priority level as held in the condition code register.
   always_ff @(posedge clock_in or negedge rst_n) begin
      if (!rst_n) begin
         cc_level_out <= awu_pkg::CC_LEVEL_RESET;
         cc_saved <= awu_pkg::CC_LEVEL_RESET;
      end else if (halt_go) begin
         cc_level_out <= awu_pkg::CC_LEVEL_OPEN;
      end else if (resume && csr.wake_flag) begin
         cc_saved <= cc_level_out;
         cc_level_out <= opts.wake_level;
      end else if (cc_pop_in) begin
         cc_level_out <= cc_saved;
      end
   end

   bus_ack_pulse_a: assert property (wb_ack_out |=> !wb_ack_out)
      else $error("bus ack held for more than one cycle");

   flag_read_clear_a: assert property (
      rd && idx == awu_pkg::IDX_CSR && !set_flag
      |=> !csr.wake_flag ##1 !wake_irq_out)
      else $error("wake flag survived a status read");

   flag_write_ignored_a: assert property (
      wr && idx == awu_pkg::IDX_CSR && !set_flag
      |=> csr.wake_flag == $past(csr.wake_flag))
      else $error("write changed the wake flag");

   wake_halt_entry_a: assert property (
      halt_go && csr.wake_enable && !irq_pending_in && !zero_pre
      |=> state == awu_pkg::AWU_ST_RC_START ##1 rc_osc_on_out)
      else $error("auto wake halt not entered");

   plain_halt_entry_a: assert property (
      halt_go && !csr.wake_enable && !irq_pending_in && !active_halt_in
      |=> state == awu_pkg::AWU_ST_HALT
      ##1 !main_osc_on_out && !periph_clk_en_out)
      else $error("plain halt not entered with clocks stopped");

   expiry_flag_a: assert property (
      state == awu_pkg::AWU_ST_COUNT && expire
      |=> csr.wake_flag && state == awu_pkg::AWU_ST_STAB)
      else $error("delay expiry did not set flag and wake");

   short_stab_a: assert property (
      $rose(state == awu_pkg::AWU_ST_STAB) && !opts.long_stab
      && !opts.pll_en |-> ##256 cpu_resume_out)
      else $error("short stabilisation delay is not 256 cycles");

   measure_route_a: assert property (
      meas_run |=> rc_osc_on_out && rc_capture_out == $past(rc_s2))
      else $error("RC clock not routed in measure mode");

   watchdog_trip_a: assert property (
      wdg_trip |=> watchdog_reset_out && state == awu_pkg::AWU_ST_RUN)
      else $error("watchdog halt option not honoured");

   pll_delay_a: assert property (
      state == awu_pkg::AWU_ST_STAB && wait_done && opts.pll_en
      |=> state == awu_pkg::AWU_ST_PLL ##1 !periph_clk_en_out)
      else $error("clock released before the PLL start-up wait");

   irq_level_a: assert property (|(evt_status & evt_mask) |=> irq_out)
      else $error("unmasked event did not raise the interrupt");
endmodule
`default_nettype wire
